// ---- wake_frame_detect.sv ----
// Purpose: Wake frame detector: pattern filters with CRC-16 and address-repeat wake.
// Assumes: Receive bytes arrive from MAC logic on clk_i with frame start and end marks.
// Notes: rx_hold_o suspends normal reception while any detection mode is active.
// Summary of operation
// R1 - Software keeps pattern offsets at twelve or more
// R2 - Offset zero is first destination byte
// R3 - Masked-byte CRC equals stored value means wake
// R4 - Address-repeat enable suspends reception and detects
// R5 - Notify by interrupt or power event output
// R6 - Address-repeat match sets its seen flag
// R7 - Clearing enable returns to normal reception
// R8 - Examine own or broadcast destination frames
// R9 - Multicast destination frames also examined
// R10 - Find six all-ones bytes after addresses
// R11 - Then sixteen back-to-back station address copies
// R12 - Broken run restarts sync search
// R13 - Sync and copies anywhere in frame
// R14 - Full power: detection only when enabled
// R15 - Light sleep forces both detections on
// R16 - Pattern enable suspends reception, sets pattern flag
// R17 - Mask bit j selects byte offset plus j
// R18 - Command bit0 enables, bit3 selects multicast
// R19 - Fixed CRC-16 polynomial and initial value
`timescale 1ns/1ns
module wake_frame_detect #(
  parameter int unsigned NUM_FILTERS = wake_pkg::NUM_FILTERS,
  parameter int unsigned ADDR_REPEATS = wake_pkg::ADDR_REPEATS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive byte stream
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  // Notification and reception control
  output logic irq_o,
  output logic power_event_out_o,
  output logic rx_hold_o
);
  logic [30:0] mask_q [NUM_FILTERS];
  logic [7:0] offset_q [NUM_FILTERS];
  logic [15:0] crc_exp_q [NUM_FILTERS];
  logic [3:0] cmd_q [NUM_FILTERS];
  logic [3:0] ctrl_q;
  logic [1:0] status_q;
  logic [1:0] irq_mask_q;
  logic [47:0] station_q;
  logic [31:0] rd_d;
  logic wr_stb;
  logic addr_active;
  logic pat_active;
  logic addr_hit;
  logic pat_hit;

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int b = 0; b < 8; b++)
    begin
      if (c[15] ^ data[b])
        c = {c[14:0], 1'b0} ^ wake_pkg::CRC_POLY;
      else
        c = {c[14:0], 1'b0};
    end
    return c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int k = 0; k < 4; k++)
    begin
      if (sel[k])
        r[k*8 +: 8] = nw[k*8 +: 8];
    end
    return r;
  endfunction

  // A write lands at the edge where the master samples ack high, while the request still stands.
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign addr_active = ctrl_q[wake_pkg::CTL_ADDR_EN] || ctrl_q[wake_pkg::CTL_LIGHT_SLEEP]; // R14 R15 R4
  assign pat_active = ctrl_q[wake_pkg::CTL_PAT_EN] || ctrl_q[wake_pkg::CTL_LIGHT_SLEEP]; // R15 R16

  // Ack one cycle after the request and drop it the next cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_comb
  begin
    rd_d = wake_pkg::RESET_ZERO;
    case (wb_adr_i)
      wake_pkg::OFS_MASK0: rd_d = {1'b0, mask_q[0]};
      wake_pkg::OFS_MASK1: rd_d = {1'b0, mask_q[1]};
      wake_pkg::OFS_MASK2: rd_d = {1'b0, mask_q[2]};
      wake_pkg::OFS_MASK3: rd_d = {1'b0, mask_q[3]};
      wake_pkg::OFS_COMMAND: rd_d = {4'h0, cmd_q[3], 4'h0, cmd_q[2], 4'h0, cmd_q[1], 4'h0, cmd_q[0]};
      wake_pkg::OFS_OFFSET: rd_d = {offset_q[3], offset_q[2], offset_q[1], offset_q[0]};
      wake_pkg::OFS_CRC01: rd_d = {crc_exp_q[1], crc_exp_q[0]};
      wake_pkg::OFS_CRC23: rd_d = {crc_exp_q[3], crc_exp_q[2]};
      wake_pkg::OFS_CONTROL: rd_d = {28'h000_0000, ctrl_q};
      wake_pkg::OFS_STATUS: rd_d = {30'h0000_0000, status_q};
      wake_pkg::OFS_IRQ_MASK: rd_d = {30'h0000_0000, irq_mask_q};
      wake_pkg::OFS_ADDR_LO: rd_d = station_q[31:0];
      wake_pkg::OFS_ADDR_HI: rd_d = {16'h0000, station_q[47:32]};
      default: rd_d = wake_pkg::RESET_ZERO;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= wake_pkg::RESET_ZERO;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
      wb_dat_o <= rd_d;
  end

  // Filter table and configuration writes; reserved bits are never stored.
  always_ff @(posedge clk_i)
  begin
    logic [31:0] w;
    w = wake_pkg::RESET_ZERO;
    if (rst_i)
    begin
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        mask_q[i] <= '0;
        offset_q[i] <= '0;
        crc_exp_q[i] <= '0;
        cmd_q[i] <= '0;
      end
      ctrl_q <= '0;
      irq_mask_q <= '0;
      station_q <= '0;
    end
    else if (wr_stb)
    begin
      w = merge(rd_d, wb_dat_i, wb_sel_i);
      case (wb_adr_i)
        wake_pkg::OFS_MASK0: mask_q[0] <= w[30:0]; // R17
        wake_pkg::OFS_MASK1: mask_q[1] <= w[30:0];
        wake_pkg::OFS_MASK2: mask_q[2] <= w[30:0];
        wake_pkg::OFS_MASK3: mask_q[3] <= w[30:0];
        wake_pkg::OFS_COMMAND:
        begin
          for (int i = 0; i < NUM_FILTERS; i++)
            cmd_q[i] <= w[i*wake_pkg::CMD_STRIDE +: 4] & 4'b1001; // R18
        end
        wake_pkg::OFS_OFFSET:
        begin
          for (int i = 0; i < NUM_FILTERS; i++)
            offset_q[i] <= w[i*8 +: 8];
        end
        wake_pkg::OFS_CRC01:
        begin
          crc_exp_q[0] <= w[15:0];
          crc_exp_q[1] <= w[31:16];
        end
        wake_pkg::OFS_CRC23:
        begin
          crc_exp_q[2] <= w[15:0];
          crc_exp_q[3] <= w[31:16];
        end
        wake_pkg::OFS_CONTROL: ctrl_q <= w[3:0]; // R7
        wake_pkg::OFS_IRQ_MASK: irq_mask_q <= w[1:0];
        wake_pkg::OFS_ADDR_LO: station_q[31:0] <= w;
        wake_pkg::OFS_ADDR_HI: station_q[47:32] <= w[15:0];
        default: ;
      endcase
    end
  end

  // Frame position and destination classification.
  logic [7:0] pos_q;
  logic in_frame_q;
  logic [47:0] dest_q;
  logic dst_ok;
  logic dst_mcast;
  logic [7:0] cur_pos;

  assign cur_pos = rx_sof_i ? 8'h00 : pos_q; // R2
  assign dst_mcast = dest_q[40] && (dest_q != '1);
  assign dst_ok = (dest_q == station_q) || (dest_q == '1) || dest_q[40]; // R8 R9

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pos_q <= '0;
      in_frame_q <= 1'b0;
      dest_q <= '0;
    end
    else if (rx_valid_i)
    begin
      in_frame_q <= !rx_eof_i;
      if (pos_q != 8'hFF || rx_sof_i)
        pos_q <= cur_pos + 8'h01;
      if (cur_pos < 8'd6)
        dest_q[47 - 8*cur_pos[2:0] -: 8] <= rx_data_i;
    end
  end

  // Address-repeat search: sync stream then sixteen station copies.
  typedef enum logic [1:0] {AR_SYNC, AR_COPIES, AR_DONE} ar_state_t;
  ar_state_t ar_q;
  logic [2:0] sync_cnt_q;
  logic [2:0] byte_cnt_q;
  logic [4:0] copy_cnt_q;
  logic [7:0] exp_byte;
  logic ar_found;

  assign exp_byte = station_q[47 - 8*byte_cnt_q -: 8];
  assign ar_found = (ar_q == AR_COPIES) && rx_valid_i && (rx_data_i == exp_byte)
                    && (byte_cnt_q == 3'd5) && (copy_cnt_q == 5'(ADDR_REPEATS - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !addr_active || (rx_valid_i && rx_sof_i))
    begin
      ar_q <= AR_SYNC;
      sync_cnt_q <= '0;
      byte_cnt_q <= '0;
      copy_cnt_q <= '0;
    end
    else if (rx_valid_i && cur_pos >= 8'(wake_pkg::HDR_BYTES) && dst_ok)
    begin
      case (ar_q)
        AR_SYNC:
        begin
          if (rx_data_i == wake_pkg::SYNC_BYTE) // R10 R13
          begin
            if (sync_cnt_q == 3'(wake_pkg::SYNC_BYTES - 1))
              ar_q <= AR_COPIES;
            else
              sync_cnt_q <= sync_cnt_q + 3'd1;
          end
          else
            sync_cnt_q <= '0;
        end
        AR_COPIES:
        begin
          if (rx_data_i == exp_byte) // R11
          begin
            byte_cnt_q <= (byte_cnt_q == 3'd5) ? 3'd0 : byte_cnt_q + 3'd1;
            if (byte_cnt_q == 3'd5)
              copy_cnt_q <= copy_cnt_q + 5'd1;
            if (ar_found)
              ar_q <= AR_DONE;
          end
          else
          begin
            ar_q <= AR_SYNC; // R12
            byte_cnt_q <= '0;
            copy_cnt_q <= '0;
            sync_cnt_q <= (rx_data_i == wake_pkg::SYNC_BYTE) ? 3'd1 : 3'd0;
          end
        end
        AR_DONE: ;
        default: ar_q <= AR_SYNC;
      endcase
    end
  end

  assign addr_hit = ar_found && addr_active && dst_ok && cur_pos >= 8'(wake_pkg::HDR_BYTES);

  // Checker helpers: bytes taken in the copy run, and all-ones bytes seen after the headers.
  localparam int unsigned ADDR_OCTETS = 6;
  logic [9:0] run_len_q;
  logic [3:0] ff_run_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || ar_q != AR_COPIES || (rx_valid_i && rx_sof_i))
      run_len_q <= '0;
    else if (rx_valid_i && run_len_q != '1)
      run_len_q <= run_len_q + 10'd1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (rx_valid_i && (rx_data_i != wake_pkg::SYNC_BYTE || cur_pos < 8'(wake_pkg::HDR_BYTES))))
      ff_run_q <= '0;
    else if (rx_valid_i && ff_run_q != '1)
      ff_run_q <= ff_run_q + 4'd1;
  end

  // Pattern filters: running CRC per filter, checked at frame end.
  logic [15:0] crc_q [NUM_FILTERS];
  logic [NUM_FILTERS-1:0] match;

  always_ff @(posedge clk_i)
  begin
    logic [7:0] rel;
    logic [15:0] base;
    rel = '0;
    base = wake_pkg::CRC_INIT;
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      base = rx_sof_i ? wake_pkg::CRC_INIT : crc_q[i];
      rel = cur_pos - offset_q[i];
      if (rst_i)
        crc_q[i] <= wake_pkg::CRC_INIT; // R19
      else if (rx_valid_i && cur_pos >= offset_q[i] && rel < 8'(wake_pkg::MASK_BITS) && mask_q[i][rel[4:0]])
        crc_q[i] <= crc16_byte(base, rx_data_i); // R2 R3 R17 R19
      else if (rx_valid_i && rx_sof_i)
        crc_q[i] <= wake_pkg::CRC_INIT;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_FILTERS; i++)
      match[i] = cmd_q[i][wake_pkg::CMD_ENABLE] && (crc_q[i] == crc_exp_q[i]) // R3
                 && (cmd_q[i][wake_pkg::CMD_MCAST] == dst_mcast); // R18
  end

  assign pat_hit = pat_active && rx_valid_i && rx_eof_i && !rx_sof_i && in_frame_q && (|match); // R16

  // Sticky seen flags: a hit wins over a write-one clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status_q <= '0;
    else
    begin
      if (wr_stb && wb_adr_i == wake_pkg::OFS_STATUS && wb_sel_i[0])
        status_q <= status_q & ~wb_dat_i[1:0];
      if (addr_hit)
        status_q[wake_pkg::ST_ADDR_SEEN] <= 1'b1; // R6
      if (pat_hit)
        status_q[wake_pkg::ST_PAT_SEEN] <= 1'b1; // R16
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      power_event_out_o <= 1'b0;
      rx_hold_o <= 1'b0;
    end
    else
    begin
      irq_o <= !ctrl_q[wake_pkg::CTL_NOTIFY_PME] && |(status_q & irq_mask_q); // R5
      power_event_out_o <= ctrl_q[wake_pkg::CTL_NOTIFY_PME] && |(status_q & irq_mask_q); // R5
      rx_hold_o <= addr_active || pat_active; // R4 R7 R16
    end
  end

  chk_hold_follows_enable: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    addr_active |=> rx_hold_o) else $error("reception not suspended");
  chk_hold_released: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    !addr_active && !pat_active |=> !rx_hold_o) else $error("reception not resumed");
  chk_addr_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // R6
    addr_hit |=> status_q[wake_pkg::ST_ADDR_SEEN]) else $error("address flag not set");
  chk_pat_flag_set: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    pat_hit |=> status_q[wake_pkg::ST_PAT_SEEN]) else $error("pattern flag not set");
  chk_sleep_forces_on: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    ctrl_q[wake_pkg::CTL_LIGHT_SLEEP] |-> addr_active && pat_active ##1 rx_hold_o) else $error("sleep not forcing");
  chk_full_power_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R14
    !ctrl_q[wake_pkg::CTL_LIGHT_SLEEP] && !ctrl_q[wake_pkg::CTL_ADDR_EN]
    |=> ar_q == AR_SYNC && sync_cnt_q == 3'd0)
    else $error("detection while disabled");
  chk_notify_path: assert property (@(posedge clk_i) disable iff (rst_i) // R5
    ##1 (irq_o || power_event_out_o) |-> $past(|(status_q & irq_mask_q))) else $error("spurious notify");
  chk_break_restarts: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    ar_q == AR_COPIES && rx_valid_i && !rx_sof_i && dst_ok && cur_pos >= 8'(wake_pkg::HDR_BYTES)
    && rx_data_i != exp_byte |=> ar_q == AR_SYNC) else $error("broken run not discarded");
  chk_wake_needs_copies: assert property (@(posedge clk_i) disable iff (rst_i) // R11
    addr_hit |-> run_len_q == 10'(ADDR_REPEATS * ADDR_OCTETS - 1)) else $error("early wake");
  chk_unfiltered_dest: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    rx_valid_i && !rx_sof_i && !dst_ok |-> ar_q == AR_SYNC && sync_cnt_q == 3'd0)
    else $error("foreign frame examined");

  sequence s_enter_copies;
    ar_q == AR_SYNC ##1 ar_q == AR_COPIES;
  endsequence
  chk_sync_before_copies: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    s_enter_copies |-> ff_run_q >= 4'(wake_pkg::SYNC_BYTES)) else $error("copies without sync stream");
endmodule

// ---- wake_pkg.sv ----
// Purpose: Shared constants for the receive-side wake frame detector.
// Assumes: Classic Wishbone register access with 32-bit data and byte addresses.
// Notes: Register offsets are byte addresses of aligned words.
package wake_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned NUM_FILTERS = 4;
  localparam int unsigned MASK_BITS = 31;
  localparam int unsigned ADDR_REPEATS = 16;
  localparam int unsigned SYNC_BYTES = 6;
  localparam int unsigned HDR_BYTES = 12;
  localparam int unsigned MIN_PATTERN_OFFSET = 12;

  localparam logic [7:0] OFS_MASK0 = 8'h00;
  localparam logic [7:0] OFS_MASK1 = 8'h04;
  localparam logic [7:0] OFS_MASK2 = 8'h08;
  localparam logic [7:0] OFS_MASK3 = 8'h0C;
  localparam logic [7:0] OFS_COMMAND = 8'h10;
  localparam logic [7:0] OFS_OFFSET = 8'h14;
  localparam logic [7:0] OFS_CRC01 = 8'h18;
  localparam logic [7:0] OFS_CRC23 = 8'h1C;
  localparam logic [7:0] OFS_CONTROL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFS_ADDR_LO = 8'h2C;
  localparam logic [7:0] OFS_ADDR_HI = 8'h30;

  localparam int unsigned CTL_ADDR_EN = 0;
  localparam int unsigned CTL_PAT_EN = 1;
  localparam int unsigned CTL_NOTIFY_PME = 2;
  localparam int unsigned CTL_LIGHT_SLEEP = 3;
  localparam int unsigned ST_ADDR_SEEN = 0;
  localparam int unsigned ST_PAT_SEEN = 1;
  localparam int unsigned CMD_ENABLE = 0;
  localparam int unsigned CMD_MCAST = 3;
  localparam int unsigned CMD_STRIDE = 8;

  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
endpackage

// ---- mac_rx_model.sv ----
// Purpose: Behavioural MAC receive datapath that feeds frame bytes to the wake detector.
// Assumes: The caller fills q and calls send just after a rising clock edge.
// Notes: Between bytes the data line shows the inverse of the last byte, so stale data is never mistaken for valid data.
`timescale 1ns/1ns
module mac_rx_model (
  // Clock
  input wire logic clk_i,
  // Receive byte stream
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_sof_o,
  output logic rx_eof_o
);
  logic [7:0] q[$];

  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_sof_o = 1'b0;
    rx_eof_o = 1'b0;
  end

  // The first byte carries the start mark and is the first destination byte.
  task automatic send(input int gap);
    for (int i = 0; i < q.size(); i++)
    begin
      rx_valid_o <= 1'b1;
      rx_data_o <= q[i];
      rx_sof_o <= (i == 0);
      rx_eof_o <= (i == q.size() - 1);
      @(posedge clk_i);
      if (gap > 0)
      begin
        rx_valid_o <= 1'b0;
        rx_sof_o <= 1'b0;
        rx_eof_o <= 1'b0;
        rx_data_o <= ~q[i];
        repeat (gap) @(posedge clk_i);
      end
    end
    rx_valid_o <= 1'b0;
    rx_sof_o <= 1'b0;
    rx_eof_o <= 1'b0;
    rx_data_o <= ~q[q.size() - 1];
  endtask
endmodule

// ---- tb_wake_frame_detect.sv ----
// Purpose: Self-checking bench for the wake frame detector.
// Assumes: Registers are reached by classic Wishbone; frames come from the receive model.
// Notes: Each address-repeat frame holds a broken run of fifteen copies before a full run.
`timescale 1ns/1ns
module tb_wake_frame_detect;
  localparam logic [47:0] STA = 48'h0211_2233_4455;
  typedef struct packed {logic [7:0] adr; logic [31:0] wd; logic [31:0] rd;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_sof;
  logic rx_eof;
  logic irq_o;
  logic power_event_out_o;
  logic rx_hold_o;
  int fails = 0;
  int tests_run = 0;
  logic [15:0] good;
  row_t rows [9];
  logic [47:0] dsts [4];
  logic [31:0] dexp [4];

  always #4 clk_i = ~clk_i;

  mac_rx_model u_mac_rx_model (.clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_sof_o(rx_sof),
    .rx_eof_o(rx_eof));

  wake_frame_detect u_wake_frame_detect (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_sof_i(rx_sof), .rx_eof_i(rx_eof), .irq_o(irq_o),
    .power_event_out_o(power_event_out_o), .rx_hold_o(rx_hold_o));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request stands until ack is seen at a rising edge.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20)
      check(32'h0000_0000, 32'h0000_0001);
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    check(r, exp);
  endtask

  // The pins are registered one edge after a bus write lands, so that edge passes first.
  task automatic pins(input logic [2:0] exp);
    @(posedge clk_i);
    check({29'h0, rx_hold_o, power_event_out_o, irq_o}, {29'h0, exp});
  endtask

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? wake_pkg::CRC_POLY : 16'h0000);
    return c;
  endfunction

  task automatic push6(input logic [47:0] v);
    for (int i = 5; i >= 0; i--)
      u_mac_rx_model.q.push_back(v[8 * i +: 8]);
  endtask

  task automatic magic(input logic [47:0] dst);
    u_mac_rx_model.q.delete();
    push6(dst);
    push6(48'hA0A1_A2A3_A4A5);
    push6(48'hFFFF_FFFF_FFFF);
    repeat (15) push6(STA);
    u_mac_rx_model.q.push_back(8'h00);
    push6(48'hFFFF_FFFF_FFFF);
    repeat (16) push6(STA);
    u_mac_rx_model.q.push_back(8'h5A);
  endtask

  task automatic run(input int gap);
    u_mac_rx_model.send(gap);
    repeat (3) @(posedge clk_i);
  endtask

  initial
  begin
    repeat (20_000) @(posedge clk_i);
    fails++;
    $display("watchdog expired at %0t", $time);
    end_sim();
  end

  initial
  begin
    rows = '{'{wake_pkg::OFS_MASK1, 32'h5555_2AAA, 32'h5555_2AAA}, '{wake_pkg::OFS_MASK3, 32'h7FFF_FFFF, 32'h7FFF_FFFF},
      '{wake_pkg::OFS_COMMAND, 32'h0908_0109, 32'h0908_0109}, '{wake_pkg::OFS_OFFSET, 32'h0C0D_0E0F, 32'h0C0D_0E0F},
      '{wake_pkg::OFS_CRC23, 32'h1234_ABCD, 32'h1234_ABCD}, '{wake_pkg::OFS_IRQ_MASK, 32'h0000_0003, 32'h0000_0003},
      '{wake_pkg::OFS_ADDR_LO, STA[31:0], STA[31:0]}, '{wake_pkg::OFS_ADDR_HI, {16'h0000, STA[47:32]}, {16'h0000, STA[47:32]}},
      '{8'h34, 32'hFFFF_FFFF, 32'h0000_0000}};
    dsts = '{STA, 48'hFFFF_FFFF_FFFF, 48'h0100_5E00_0001, 48'h0200_0000_0099};
    dexp = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0000};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    pins(3'b000);
    foreach (rows[k])
    begin
      rchk(rows[k].adr, wake_pkg::RESET_ZERO);
      wr(rows[k].adr, rows[k].wd);
      rchk(rows[k].adr, rows[k].rd);
    end
    for (int k = 0; k < 4; k++)
    begin
      wr(wake_pkg::OFS_CONTROL, 32'h0000_0001 | (32'(k % 2) << wake_pkg::CTL_NOTIFY_PME));
      magic(dsts[k]);
      run(0);
      rchk(wake_pkg::OFS_STATUS, dexp[k]);
      pins({1'b1, dexp[k][0] & k[0], dexp[k][0] & ~k[0]});
      wr(wake_pkg::OFS_STATUS, 32'h0000_0003);
    end
    wr(wake_pkg::OFS_CONTROL, 32'h0000_0000);
    pins(3'b000);
    magic(STA);
    run(0);
    rchk(wake_pkg::OFS_STATUS, 32'h0000_0000);
    wr(wake_pkg::OFS_CONTROL, 32'h0000_0008);
    run(0);
    rchk(wake_pkg::OFS_STATUS, 32'h0000_0001);
    wr(wake_pkg::OFS_STATUS, 32'h0000_0003);
    wr(wake_pkg::OFS_CONTROL, 32'h0000_0000);
    // Filter 0 checks bytes 12 and 14 of a frame whose payload bytes equal their position.
    wr(wake_pkg::OFS_MASK0, 32'h0000_0005);
    wr(wake_pkg::OFS_OFFSET, 32'h0000_000C);
    wr(wake_pkg::OFS_COMMAND, 32'h0000_0001);
    good = crc_step(crc_step(wake_pkg::CRC_INIT, 8'h0C), 8'h0E);
    wr(wake_pkg::OFS_CRC01, {16'h0000, good ^ 16'h0001});
    wr(wake_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    wr(wake_pkg::OFS_CONTROL, 32'h0000_0002);
    pins(3'b100);
    u_mac_rx_model.q.delete();
    push6(STA);
    for (int i = 6; i < 40; i++)
      u_mac_rx_model.q.push_back(8'(i));
    run(2);
    rchk(wake_pkg::OFS_STATUS, 32'h0000_0000);
    wr(wake_pkg::OFS_CRC01, {16'h0000, good});
    run(2);
    rchk(wake_pkg::OFS_STATUS, 32'h0000_0002);
    pins(3'b100);
    wr(wake_pkg::OFS_IRQ_MASK, 32'h0000_0003);
    repeat (2) @(posedge clk_i);
    pins(3'b101);
    wr(wake_pkg::OFS_STATUS, 32'h0000_0003);
    repeat (2) @(posedge clk_i);
    pins(3'b100);
    wr(wake_pkg::OFS_COMMAND, 32'h0000_0009);
    run(2);
    rchk(wake_pkg::OFS_STATUS, 32'h0000_0000);
    // Reset in mid-run clears the configuration and the pins.
    wr(wake_pkg::OFS_CONTROL, 32'h0000_0001);
    pins(3'b100);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    pins(3'b000);
    rchk(wake_pkg::OFS_CONTROL, wake_pkg::RESET_ZERO);
    rchk(wake_pkg::OFS_OFFSET, wake_pkg::RESET_ZERO);
    end_sim();
  end
endmodule
